/* rtl/skip_on_zero_regs.svh */
// Constants for the move-and-skip and no-operation decoder.
`ifndef SKIP_ON_ZERO_REGS_SVH
`define SKIP_ON_ZERO_REGS_SVH
`define OPC_WIDTH 12
`define DATA_WIDTH 8
`define ADDR_WIDTH 5
`define OPC_DEC_TOP 7'h16
`define OPC_INC_TOP 7'h1E
`define OPC_NOP 12'h000
`define CYCLES_NOSKIP 1
`define CYCLES_SKIP 2
`endif

/* rtl/skip_on_zero_pkg.sv */
// Types shared by the move-and-skip decoder files.
package skip_on_zero_pkg;
  typedef enum logic [1:0] {
    OP_OTHER,
    OP_DEC,
    OP_INC,
    OP_NOP
  } op_kind_t;
endpackage

/* rtl/opcode_classifier.sv */
// Opcode classifier for the move-and-skip and no-operation instructions.
`timescale 1ns/1ps
`include "skip_on_zero_regs.svh"
module opcode_classifier
  import skip_on_zero_pkg::*;
(
  // Instruction word
  input wire logic [`OPC_WIDTH-1:0] i_opcode,
  // Decoded class
  output op_kind_t o_kind
);
  wire logic is_dec;
  wire logic is_inc;
  wire logic is_nop;
  assign is_dec = (i_opcode[11:5] == `OPC_DEC_TOP);
  assign is_inc = (i_opcode[11:5] == `OPC_INC_TOP);
  assign is_nop = (i_opcode == `OPC_NOP);
  assign o_kind = is_dec ? OP_DEC : is_inc ? OP_INC :
                  is_nop ? OP_NOP : OP_OTHER;
endmodule

/* rtl/move_modified_skip_if_zero.sv */
// Execute logic for the move-and-skip and no-operation instructions.
// Notes on behaviour
// RULE1: Decrement form loads W with operand minus one.
// RULE2: Increment form loads W with operand plus one.
// RULE3: Zero result skips the next instruction.
// RULE4: One cycle normally, two when skipping.
// RULE5: All-zero opcode only spends one cycle.
// RULE6: Software separates same-port read-modify-writes with no-op.
// RULE7: Status flags are never touched.
`timescale 1ns/1ps
`include "skip_on_zero_regs.svh"
module move_modified_skip_if_zero
  import skip_on_zero_pkg::*;
#(
  parameter int DW = `DATA_WIDTH
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // Instruction issue
  input wire logic I_VALID,
  input wire logic [`OPC_WIDTH-1:0] I_OPCODE,
  // File register read port
  input wire logic [DW-1:0] I_FILE_REGISTER_OPERAND,
  output logic [`ADDR_WIDTH-1:0] O_OPERAND_ADDR,
  // Accumulator write
  output logic O_W_WE,
  output logic [DW-1:0] O_W_DATA,
  // Sequencing
  output logic O_SKIP,
  output logic O_BUSY,
  output logic O_DONE,
  // Side effects, always idle
  output logic O_OPERAND_WE,
  output logic O_FLAGS_WE
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  op_kind_t kind;
  wire logic take;
  wire logic is_move;
  wire logic [DW-1:0] result;
  wire logic zero;
  wire logic we_d;
  wire logic skip_d;
  wire logic busy_d;
  wire logic done_d;
  wire logic [DW-1:0] w_d;
  wire logic [1:0] cost_d;
  logic we_q;
  logic skip_q;
  logic busy_q;
  logic done_q;
  logic [DW-1:0] w_q;
  logic [1:0] cost_q;

  opcode_classifier u_cls (
    .i_opcode(I_OPCODE),
    .o_kind(kind)
  );

  // The read port is combinational, so the address follows the opcode.
  assign take = I_VALID && !busy_q;
  assign is_move = (kind == OP_DEC) || (kind == OP_INC);
  assign result = (kind == OP_DEC) ?
                  I_FILE_REGISTER_OPERAND - DW'(1) : // RULE1
                  I_FILE_REGISTER_OPERAND + DW'(1); // RULE2
  assign zero = (result == '0);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign we_d = take && is_move;
  assign skip_d = we_d && zero; // RULE3
  // A skip holds busy for one extra cycle so the squashed slot is paid.
  // Whatever fetch offers during that cycle is refused here, since take needs !busy_q.
  assign busy_d = skip_d; // RULE4
  assign done_d = take && (kind != OP_OTHER); // RULE5
  // W keeps its last result; nothing but a move replaces it.
  assign w_d = we_d ? result : w_q;
  // Cycles charged to the latest move; only the checks read this.
  assign cost_d = we_d ? 2'(`CYCLES_NOSKIP) :
                  busy_q ? cost_q + 2'(1) : cost_q;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      we_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      we_q <= we_d;
      skip_q <= skip_d;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      w_q <= '0;
      cost_q <= '0;
    end else begin
      w_q <= w_d;
      cost_q <= cost_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_OPERAND_ADDR = I_OPCODE[`ADDR_WIDTH-1:0];
  assign O_W_WE = we_q;
  assign O_W_DATA = w_q;
  assign O_SKIP = skip_q;
  assign O_BUSY = busy_q;
  assign O_DONE = done_q;
  // Nothing here writes the file register or the status bits.
  assign O_OPERAND_WE = 1'b0; // RULE1
  assign O_FLAGS_WE = 1'b0; // RULE7

  // ----------------------------------------------------------------
  // Checks on results
  // ----------------------------------------------------------------
  a_dec_value: assert property (@(posedge I_CLK) disable iff (I_SRST) // RULE1
    take && kind == OP_DEC |=> O_W_WE &&
      O_W_DATA == $past(I_FILE_REGISTER_OPERAND) - DW'(1))
    else $error("decrement result wrong");

  a_inc_value: assert property (@(posedge I_CLK) disable iff (I_SRST) // RULE2
    take && kind == OP_INC |=> O_W_WE &&
      O_W_DATA == $past(I_FILE_REGISTER_OPERAND) + DW'(1))
    else $error("increment result wrong");

  a_dec_skip: assert property (@(posedge I_CLK) disable iff (I_SRST) // RULE3
    take && kind == OP_DEC && I_FILE_REGISTER_OPERAND == DW'(1) |=> O_SKIP)
    else $error("decrement to zero did not skip");

  a_inc_skip: assert property (@(posedge I_CLK) disable iff (I_SRST) // RULE3
    take && kind == OP_INC && I_FILE_REGISTER_OPERAND == '1 |=> O_SKIP)
    else $error("increment to zero did not skip");

  a_skip_zero: assert property (@(posedge I_CLK) disable iff (I_SRST) // RULE3
    O_W_WE |-> (O_SKIP == (O_W_DATA == '0)))
    else $error("skip does not match zero result");

  a_skip_move: assert property (@(posedge I_CLK) disable iff (I_SRST) // RULE3
    O_SKIP |-> O_W_WE && O_DONE)
    else $error("skip without a completed move");

  // ----------------------------------------------------------------
  // Checks on sequencing
  // ----------------------------------------------------------------
  // A refused request leaves no trace, so fetch may simply offer it again.
  a_skip_cycle: assert property (@(posedge I_CLK) disable iff (I_SRST) // RULE4
    O_SKIP |-> O_BUSY ##1 !O_BUSY)
    else $error("skip must cost exactly one extra cycle");

  a_noskip_free: assert property (@(posedge I_CLK) // RULE4
    disable iff (I_SRST)
    O_W_WE && !O_SKIP |-> !O_BUSY)
    else $error("nonzero result must not stall");

  a_skip_cost: assert property (@(posedge I_CLK) disable iff (I_SRST) // RULE4
    O_W_WE && O_SKIP |=> cost_q == 2'(`CYCLES_SKIP))
    else $error("skipping move did not take two cycles");

  a_plain_cost: assert property (@(posedge I_CLK) disable iff (I_SRST) // RULE4
    O_W_WE && !O_SKIP |-> cost_q == 2'(`CYCLES_NOSKIP))
    else $error("plain move did not take one cycle");

  a_busy_drop: assert property (@(posedge I_CLK) disable iff (I_SRST) // RULE4
    O_BUSY |=> !O_W_WE && !O_DONE)
    else $error("request accepted during the skip cycle");

  a_busy_cause: assert property (@(posedge I_CLK) disable iff (I_SRST) // RULE4
    O_BUSY |-> O_SKIP)
    else $error("stall without a skip");

  a_move_done: assert property (@(posedge I_CLK) disable iff (I_SRST) // RULE4
    O_W_WE |-> O_DONE)
    else $error("move finished without done");

  // ----------------------------------------------------------------
  // Checks on idle behaviour
  // ----------------------------------------------------------------
  // Unknown opcodes belong to other decoders and must pass unnoticed.
  a_nop_quiet: assert property (@(posedge I_CLK) disable iff (I_SRST) // RULE5
    take && kind == OP_NOP |=> O_DONE && !O_W_WE && !O_SKIP && !O_BUSY)
    else $error("no-op changed state");

  a_nop_keeps_w: assert property (@(posedge I_CLK) // RULE5
    disable iff (I_SRST)
    take && kind == OP_NOP |=> $stable(O_W_DATA))
    else $error("no-op changed the accumulator");

  a_flags_idle: assert property (@(posedge I_CLK) disable iff (I_SRST) // RULE7
    !O_FLAGS_WE && !O_OPERAND_WE)
    else $error("flags or file register written");

  a_other_ignored: assert property (@(posedge I_CLK) // RULE3
    disable iff (I_SRST)
    take && kind == OP_OTHER |=> !O_W_WE && !O_DONE)
    else $error("foreign opcode acted on");

  a_other_noskip: assert property (@(posedge I_CLK) // RULE3
    disable iff (I_SRST)
    take && kind == OP_OTHER |=> !O_SKIP && !O_BUSY)
    else $error("foreign opcode caused a skip");
endmodule

/* dv/move_modified_skip_if_zero_test.sv */
// Self-checking testbench for the move-and-skip and no-operation decoder.
`timescale 1ns/1ps
module move_modified_skip_if_zero_test;
  localparam logic [11:0] DEC = 12'h2C0;
  localparam logic [11:0] INC = 12'h3C0;
  logic clk = 1'b0, srst = 1'b1, valid = 1'b0;
  logic [11:0] opcode = 12'h000;
  logic [7:0] operand = 8'h00, w_data;
  logic [4:0] operand_addr;
  logic w_we, skip, busy, done, operand_we, flags_we;
  int n_errors = 0, total_checks = 0;
  move_modified_skip_if_zero move_modified_skip_if_zero_i (
    .I_CLK(clk), .I_SRST(srst), .I_VALID(valid), .I_OPCODE(opcode),
    .I_FILE_REGISTER_OPERAND(operand), .O_OPERAND_ADDR(operand_addr),
    .O_W_WE(w_we), .O_W_DATA(w_data), .O_SKIP(skip), .O_BUSY(busy),
    .O_DONE(done), .O_OPERAND_WE(operand_we), .O_FLAGS_WE(flags_we));
  initial forever #5 clk = ~clk;
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request for exactly one taking edge, then samples the pulses.
  task automatic exec(input logic [11:0] opc, input logic [7:0] opd,
                      input logic mv, input logic dn,
                      input logic [7:0] res);
    @(posedge clk);
    valid <= 1'b1;
    opcode <= opc;
    operand <= opd;
    @(posedge clk);
    valid <= 1'b0;
    #1;
    cmp(operand_addr, opc[4:0]);
    cmp({w_we, skip, busy, done}, {mv, {2{mv && res == 8'h00}}, dn});
    cmp(w_data, res);
    cmp({operand_we, flags_we}, 12'h000);
  endtask
  task automatic t_dec();
    exec(DEC | 12'h01F, 8'h01, 1'b1, 1'b1, 8'h00);
    exec(DEC | 12'h018, 8'h75, 1'b1, 1'b1, 8'h74);
    exec(DEC, 8'h00, 1'b1, 1'b1, 8'hFF);
    $display("decrement test done");
  endtask
  task automatic t_inc();
    exec(INC | 12'h01F, 8'hFF, 1'b1, 1'b1, 8'h00);
    exec(INC | 12'h00A, 8'h75, 1'b1, 1'b1, 8'h76);
    exec(12'h000, 8'h55, 1'b0, 1'b1, 8'h76);
    exec(12'h2A0, 8'h55, 1'b0, 1'b0, 8'h76);
    cmp(done, 1'b0);
    $display("increment and idle test done");
  endtask
  // A skip stalls one cycle; a request then is dropped and must be re-sent.
  task automatic t_stall();
    @(posedge clk);
    valid <= 1'b1;
    opcode <= DEC | 12'h003;
    operand <= 8'h01;
    @(posedge clk);
    opcode <= INC | 12'h004;
    operand <= 8'h10;
    #1 cmp({skip, busy, done}, 12'h007);
    @(posedge clk);
    #1 cmp({w_we, busy, done}, 12'h000);
    @(posedge clk);
    operand <= 8'h20;
    #1 cmp({done, w_data}, 12'h111);
    @(posedge clk);
    valid <= 1'b0;
    #1 cmp({done, skip, w_data}, 12'h221);
    $display("stall test done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #5000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_dec();
    t_inc();
    t_stall();
    tally_and_finish();
  end
endmodule
